// file: pin_load_model.sv
// load model on the channel pins: pull-down, high and edge counters
`timescale 1ns/100ps
`default_nettype none

module pin_load_model #(
   parameter int NUM_CH = 2
) (
   input wire logic core_clk,
   input wire logic clear,
   input wire logic [NUM_CH-1:0] chPinOut,
   input wire logic [NUM_CH-1:0] chPinOe,
   output logic [NUM_CH-1:0] pinLevel,
   output int highCount [NUM_CH],
   output int edgeCount [NUM_CH]
);
   logic [NUM_CH-1:0] lastLevel;

   // a released pin falls to the board pull-down
   assign pinLevel = chPinOut & chPinOe;

   // count high samples and level changes of each pin
   always_ff @(posedge core_clk) begin
      lastLevel <= pinLevel;
      for (int i = 0; i < NUM_CH; i++) begin
         highCount[i] <= clear ? 0 : highCount[i] + int'(pinLevel[i]);
         edgeCount[i] <= clear ? 0 : edgeCount[i] + int'(pinLevel[i] != lastLevel[i]);
      end
   end
endmodule : pin_load_model

`default_nettype wire

// file: timer_compare_pwm_channels.sv
// channel logic of a 16-bit timer: output compare, edge and center aligned pwm
//
// Behaviour
// - output compare match sets, clears or toggles the pin per configured action
// - compare buffers move after both bytes; immediately if clock off, else next count change
// - channel control write discards pending value bytes and restarts the byte pairing
// - each compare match sets the channel flag; enabled flag raises interrupt request
// - edge pwm counts up only; period modulus plus one; pulse overflow to match
// - edge pwm polarity 0: overflow high, match low; polarity 1 inverts both
// - edge pwm value zero gives 0% duty; value above modulus gives 100%
// - edge pwm buffers transfer when counter steps modulus minus one to modulus
// - center pwm counts up and down; pulse twice value, period twice modulus
// - center pwm value zero or bit 15 set gives 0%; above modulus 100%
// - center pwm polarity 0: up match drives low, down match drives high
// - modulus and channel value byte writes land in buffers, not active registers
// - center pwm buffers transfer at modulus minus one to modulus, or at once if clock off
// - timer control write discards pending modulus bytes and restarts their pairing
// - center pwm raises overflow flag at end of the count equal to modulus
// - every system reset resets the whole timer
// - reset clears control, clock, center, mode and edge bits; pins released
// - edge pwm channels run beside compare and capture channels with center mode off
// - clock select 00 stops, 01 bus clock, 10 fixed clock, 11 external
// - up/down counter goes 0 to terminal and back, each value one timer clock
// - flag clears by read while set then write 0; new event keeps it set
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module timer_compare_pwm_channels #(
   parameter int NUM_CH = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire timer_pwm_pkg::apb_req_type apbReq,
   output timer_pwm_pkg::apb_rsp_type apbRsp,
   input wire logic fixedClkTick,
   input wire logic extClkPin,
   output logic [NUM_CH-1:0] chPinOut,
   output logic [NUM_CH-1:0] chPinOe,
   output logic [NUM_CH-1:0] chIrq,
   output logic ovfIrq
);

   // ==================================================================
   // elaboration check
   if (NUM_CH < 1 || NUM_CH > timer_pwm_pkg::MAX_CHANNELS) begin : gen_bad_count
      $error("NUM_CH must be 1 to 8");
   end

   // ==================================================================
   // whole state of the block
   typedef struct packed {
      timer_pwm_pkg::apb_rsp_type rsp;
      logic overflow_flag;
      logic tofArmed;
      logic overflow_irq_enable;
      logic center_align_select;
      logic [1:0] cs;
      logic [2:0] ps;
      logic [6:0] pre;
      logic [15:0] cnt;
      logic dirDown;
      logic [15:0] mod;
      logic [7:0] modBufHi;
      logic [7:0] modBufLo;
      logic modGotHi;
      logic modGotLo;
      logic [1:0] extSync;
      logic extPrev;
      logic irq;
      timer_pwm_pkg::chan_type [NUM_CH-1:0] ch;
   } state_type;

   state_type q;
   state_type d;

   // ==================================================================
   // next state
   always_comb begin
      logic srcTick;
      logic tick;
      logic ovf;
      logic xferPt;
      logic [7:0] preMask;
      logic [15:0] term;
      logic [15:0] cntNext;
      logic dirNext;
      logic setup;
      logic access;
      logic [31:0] rd;
      logic hit;
      logic [11:0] base;
      logic [7:0] wb;
      logic oc;
      logic ep;
      logic match;
      logic act;
      logic xfer;
      srcTick = 1'b0;
      tick = 1'b0;
      ovf = 1'b0;
      xferPt = 1'b0;
      preMask = 8'h00;
      term = timer_pwm_pkg::COUNT_FULL;
      cntNext = q.cnt;
      dirNext = q.dirDown;
      setup = 1'b0;
      access = 1'b0;
      rd = 32'h0000_0000;
      hit = 1'b0;
      base = 12'h000;
      wb = apbReq.pwdata[7:0];
      oc = 1'b0;
      ep = 1'b0;
      match = 1'b0;
      act = 1'b0;
      xfer = 1'b0;
      d = q;

      // external clock synchroniser and rising edge detect
      d.extSync = {q.extSync[0], extClkPin};
      d.extPrev = q.extSync[1];

      // clock source and prescaler
      case (q.cs)
         timer_pwm_pkg::CLK_BUS: srcTick = 1'b1;
         timer_pwm_pkg::CLK_FIXED: srcTick = fixedClkTick;
         timer_pwm_pkg::CLK_EXTERNAL: srcTick = q.extSync[1] & ~q.extPrev;
         default: srcTick = 1'b0;
      endcase
      preMask = (8'h01 << q.ps) - 8'h01;
      tick = srcTick && ((q.pre & preMask[6:0]) == preMask[6:0]);
      if (srcTick) begin
         d.pre = tick ? 7'h00 : q.pre + 7'h01;
      end

      // counter: up with wrap, or up/down in center mode
      term = (q.mod == timer_pwm_pkg::COUNT_ZERO) ? timer_pwm_pkg::COUNT_FULL : q.mod;
      if (tick) begin
         if (!q.center_align_select) begin
            dirNext = 1'b0;
            if (q.cnt == term) begin
               cntNext = timer_pwm_pkg::COUNT_ZERO;
               ovf = 1'b1;
            end else begin
               cntNext = q.cnt + timer_pwm_pkg::COUNT_ONE;
            end
         end else if (!q.dirDown) begin
            if (q.cnt == q.mod && q.mod != timer_pwm_pkg::COUNT_ZERO) begin
               cntNext = q.cnt - timer_pwm_pkg::COUNT_ONE;
               dirNext = 1'b1;
               ovf = 1'b1;
            end else begin
               cntNext = q.cnt + timer_pwm_pkg::COUNT_ONE;
            end
         end else if (q.cnt == timer_pwm_pkg::COUNT_ZERO) begin
            cntNext = timer_pwm_pkg::COUNT_ONE;
            dirNext = 1'b0;
         end else begin
            cntNext = q.cnt - timer_pwm_pkg::COUNT_ONE;
         end
      end
      xferPt = tick && !dirNext && cntNext == term && q.cnt == term - timer_pwm_pkg::COUNT_ONE;
      d.cnt = cntNext;
      d.dirDown = dirNext;

      // apb: decode and read data in setup, effects at the completing access edge
      setup = apbReq.psel && !apbReq.penable;
      access = apbReq.psel && apbReq.penable && q.rsp.pready;
      case (apbReq.paddr)
         timer_pwm_pkg::TIMER_CONTROL_OFS: begin
            rd[7:0] = {q.overflow_flag, q.overflow_irq_enable, q.center_align_select, q.cs, q.ps};
            hit = 1'b1;
         end
         timer_pwm_pkg::COUNTER_HIGH_OFS: begin
            rd[7:0] = q.cnt[15:8];
            hit = 1'b1;
         end
         timer_pwm_pkg::COUNTER_LOW_OFS: begin
            rd[7:0] = q.cnt[7:0];
            hit = 1'b1;
         end
         timer_pwm_pkg::MODULUS_HIGH_OFS: begin
            rd[7:0] = q.mod[15:8];
            hit = 1'b1;
         end
         timer_pwm_pkg::MODULUS_LOW_OFS: begin
            rd[7:0] = q.mod[7:0];
            hit = 1'b1;
         end
         default: hit = 1'b0;
      endcase
      for (int i = 0; i < NUM_CH; i++) begin
         base = timer_pwm_pkg::CHANNEL_BASE_OFS + 12'(i) * timer_pwm_pkg::CHANNEL_STRIDE;
         if (apbReq.paddr == base + timer_pwm_pkg::CH_CONTROL_OFS) begin
            rd[7:0] = {q.ch[i].flag, q.ch[i].ie, q.ch[i].modeB, q.ch[i].modeA,
                       q.ch[i].elsB, q.ch[i].elsA, 2'h0};
            hit = 1'b1;
         end else if (apbReq.paddr == base + timer_pwm_pkg::CH_VALUE_HIGH_OFS) begin
            rd[7:0] = q.ch[i].val[15:8];
            hit = 1'b1;
         end else if (apbReq.paddr == base + timer_pwm_pkg::CH_VALUE_LOW_OFS) begin
            rd[7:0] = q.ch[i].val[7:0];
            hit = 1'b1;
         end
      end
      if (setup) begin
         d.rsp.pready = 1'b1;
         d.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rd;
         d.rsp.pslverr = ~hit;
      end else begin
         d.rsp.pready = 1'b0;
         d.rsp.pslverr = 1'b0;
      end

      // timer registers written or read by software
      if (access && apbReq.paddr == timer_pwm_pkg::TIMER_CONTROL_OFS) begin
         if (apbReq.pwrite) begin
            d.overflow_irq_enable = wb[timer_pwm_pkg::TC_OVERFLOW_IRQ_ENABLE];
            d.center_align_select = wb[timer_pwm_pkg::TC_CENTER_ALIGN];
            d.cs = wb[timer_pwm_pkg::TC_CLOCK_SEL_HI:timer_pwm_pkg::TC_CLOCK_SEL_LO];
            d.ps = wb[timer_pwm_pkg::TC_PRESCALE_HI:timer_pwm_pkg::TC_PRESCALE_LO];
            if (!wb[timer_pwm_pkg::TC_OVERFLOW_FLAG] && q.tofArmed) begin
               d.overflow_flag = 1'b0;
            end
            d.tofArmed = 1'b0;
            d.modGotHi = 1'b0;
            d.modGotLo = 1'b0;
         end else if (q.overflow_flag) begin
            d.tofArmed = 1'b1;
         end
      end
      if (access && apbReq.pwrite) begin
         if (apbReq.paddr == timer_pwm_pkg::COUNTER_HIGH_OFS ||
             apbReq.paddr == timer_pwm_pkg::COUNTER_LOW_OFS) begin
            d.cnt = timer_pwm_pkg::COUNT_ZERO;  // manual counter reset
            d.dirDown = 1'b0;
            d.pre = 7'h00;
         end
         if (apbReq.paddr == timer_pwm_pkg::MODULUS_HIGH_OFS) begin
            d.modBufHi = wb;
            d.modGotHi = 1'b1;
         end
         if (apbReq.paddr == timer_pwm_pkg::MODULUS_LOW_OFS) begin
            d.modBufLo = wb;
            d.modGotLo = 1'b1;
         end
      end
      // modulus moves at once with clock off, else at the next count change
      if (d.modGotHi && d.modGotLo && (q.cs == timer_pwm_pkg::CLK_OFF || tick)) begin
         d.mod = {d.modBufHi, d.modBufLo};
         d.modGotHi = 1'b0;
         d.modGotLo = 1'b0;
      end
      // overflow set wins over a clear in the same cycle
      if (ovf) begin
         d.overflow_flag = 1'b1;
         d.tofArmed = 1'b0;
      end
      d.irq = d.overflow_flag && d.overflow_irq_enable;

      // channels
      for (int i = 0; i < NUM_CH; i++) begin
         base = timer_pwm_pkg::CHANNEL_BASE_OFS + 12'(i) * timer_pwm_pkg::CHANNEL_STRIDE;
         oc = !q.center_align_select && !q.ch[i].modeB && q.ch[i].modeA;
         ep = !q.center_align_select && q.ch[i].modeB;
         if (access && apbReq.paddr == base + timer_pwm_pkg::CH_CONTROL_OFS) begin
            if (apbReq.pwrite) begin
               d.ch[i].ie = wb[timer_pwm_pkg::CC_IRQ_ENABLE];
               d.ch[i].modeB = wb[timer_pwm_pkg::CC_MODE_B];
               d.ch[i].modeA = wb[timer_pwm_pkg::CC_MODE_A];
               d.ch[i].elsB = wb[timer_pwm_pkg::CC_EDGE_LEVEL_B];
               d.ch[i].elsA = wb[timer_pwm_pkg::CC_EDGE_LEVEL_A];
               if (!wb[timer_pwm_pkg::CC_EVENT_FLAG] && q.ch[i].armed) begin
                  d.ch[i].flag = 1'b0;
               end
               d.ch[i].armed = 1'b0;
               d.ch[i].gotHi = 1'b0;
               d.ch[i].gotLo = 1'b0;
            end else if (q.ch[i].flag) begin
               d.ch[i].armed = 1'b1;
            end
         end
         // value bytes are refused while the channel captures
         if (access && apbReq.pwrite && (oc || ep || q.center_align_select)) begin
            if (apbReq.paddr == base + timer_pwm_pkg::CH_VALUE_HIGH_OFS) begin
               d.ch[i].bufHi = wb;
               d.ch[i].gotHi = 1'b1;
            end
            if (apbReq.paddr == base + timer_pwm_pkg::CH_VALUE_LOW_OFS) begin
               d.ch[i].bufLo = wb;
               d.ch[i].gotLo = 1'b1;
            end
         end
         // buffer transfer point depends on mode and clock select
         if (q.cs == timer_pwm_pkg::CLK_OFF) begin
            xfer = 1'b1;
         end else if (ep) begin
            xfer = xferPt;
         end else if (q.center_align_select) begin
            xfer = xferPt;
         end else begin
            xfer = tick;
         end
         if (d.ch[i].gotHi && d.ch[i].gotLo && xfer) begin
            d.ch[i].val = {d.ch[i].bufHi, d.ch[i].bufLo};
            d.ch[i].gotHi = 1'b0;
            d.ch[i].gotLo = 1'b0;
         end

         // match on the value the counter moves to
         match = tick && cntNext == q.ch[i].val;
         act = ~q.ch[i].elsA;
         if (q.center_align_select) begin
            if (q.ch[i].val == timer_pwm_pkg::COUNT_ZERO || q.ch[i].val[15]) begin
               d.ch[i].out = ~act;
            end else if (q.mod != timer_pwm_pkg::COUNT_ZERO && q.ch[i].val > q.mod) begin
               d.ch[i].out = act;
            end else if (match) begin
               // a match at the terminal count opens the down slope, so value equal to modulus is full width
               d.ch[i].out = (dirNext || cntNext == q.mod) ? act : ~act;
            end
         end else if (ep) begin
            if (tick && ovf) begin
               d.ch[i].out = act;
            end
            if (match) begin
               d.ch[i].out = ~act;
            end
         end else if (oc && match) begin
            case ({q.ch[i].elsB, q.ch[i].elsA})
               2'h1: d.ch[i].out = ~q.ch[i].out;
               2'h2: d.ch[i].out = 1'b0;
               2'h3: d.ch[i].out = 1'b1;
               default: d.ch[i].out = q.ch[i].out;
            endcase
         end
         // pin is driven only by compare or pwm channels with an action selected
         d.ch[i].oe = (oc || ep || q.center_align_select) && (q.ch[i].elsB || q.ch[i].elsA);
         if ((oc || ep || q.center_align_select) && match) begin
            d.ch[i].flag = 1'b1;
            d.ch[i].armed = 1'b0;
         end
         d.ch[i].irq = d.ch[i].flag && d.ch[i].ie;
      end
   end

   // ==================================================================
   // state register, synchronous reset clears everything
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // outputs from the state register
   assign apbRsp = q.rsp;
   assign ovfIrq = q.irq;

   // per channel output taps
   for (genvar g = 0; g < NUM_CH; g++) begin : gen_out
      assign chPinOut[g] = q.ch[g].out;
      assign chPinOe[g] = q.ch[g].oe;
      assign chIrq[g] = q.ch[g].irq;
   end

endmodule : timer_compare_pwm_channels

`default_nettype wire

// file: timer_compare_pwm_channels_assertions.sv
// concurrent checks on the ports of the timer channel block
`timescale 1ns/100ps
`default_nettype none

module timer_checks #(
   parameter int NUM_CH = 2
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire timer_pwm_pkg::apb_req_type apbReq,
   input wire timer_pwm_pkg::apb_rsp_type apbRsp,
   input wire logic [NUM_CH-1:0] chPinOut,
   input wire logic [NUM_CH-1:0] chPinOe,
   input wire logic [NUM_CH-1:0] chIrq,
   input wire logic ovfIrq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic setup, al, mapped, wr, tcW, ch0W;

   // ==================================================================
   // decode of bus phases and address map
   assign setup = apbReq.psel && !apbReq.penable;
   assign al = apbReq.paddr[1:0] == 2'h0;
   assign mapped = al && (apbReq.paddr < 12'h014 || (apbReq.paddr >= 12'h020
      && apbReq.paddr[3:0] < 4'hc && apbReq.paddr < 12'(12'h020 + 16 * NUM_CH)));
   assign wr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
   assign tcW = wr && apbReq.paddr == 12'h000;
   assign ch0W = wr && apbReq.paddr == 12'h020;

   // ==================================================================
   // properties
   property p_ready; setup |=> apbRsp.pready; endproperty
   property p_ready_one; apbRsp.pready |=> !apbRsp.pready; endproperty
   property p_err_access; apbRsp.pslverr |-> apbRsp.pready && apbReq.penable; endproperty
   property p_upper; apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0; endproperty
   property p_unmapped; setup && al && !mapped |=> apbRsp.pslverr && apbRsp.prdata == 32'h0; endproperty
   property p_mapped; setup && mapped |=> !apbRsp.pslverr; endproperty
   property p_reset;
      disable iff (1'b0) rst |=> chPinOe == '0 && chIrq == '0 && !ovfIrq;
   endproperty
   property p_oe_cause; $rose(chPinOe[0]) |-> $past(tcW || ch0W) || $past(tcW || ch0W, 2); endproperty
   property p_irq_fall; $fell(chIrq[0]) |-> $past(ch0W) || $past(ch0W, 2) || $past(ch0W, 3); endproperty
   property p_ovf_fall; $fell(ovfIrq) |-> $past(tcW) || $past(tcW, 2) || $past(tcW, 3); endproperty

   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_ready_one: assert property (p_ready_one) else $error("ready held too long");
   a_err_access: assert property (p_err_access) else $error("error outside access");
   a_upper: assert property (p_upper) else $error("upper read bits not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
   a_mapped: assert property (p_mapped) else $error("mapped address refused");
   a_reset: assert property (p_reset) else $error("outputs active after reset");
   a_oe_cause: assert property (p_oe_cause) else $error("pin enabled without write");
   a_irq_fall: assert property (p_irq_fall) else $error("channel irq dropped alone");
   a_ovf_fall: assert property (p_ovf_fall) else $error("overflow irq dropped alone");

   c_unmapped: cover property (setup && al && !mapped);
   c_irq: cover property ($rose(chIrq[0]));
   c_ovf: cover property ($rose(ovfIrq));
   c_pin: cover property ($rose(chPinOut[0]));
endmodule : timer_checks

bind timer_compare_pwm_channels timer_checks #(.NUM_CH(NUM_CH)) i_timer_checks (.core_clk(core_clk),
   .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .chPinOut(chPinOut), .chPinOe(chPinOe),
   .chIrq(chIrq), .ovfIrq(ovfIrq));

`default_nettype wire

// file: timer_compare_pwm_channels_test.sv
// self-checking bench for the timer compare and pwm channels
`timescale 1ns/100ps
`default_nettype none

module timer_compare_pwm_channels_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clear = 1'b1;
   logic fixedClkTick = 1'b0;
   logic extClkPin = 1'b0;
   timer_pwm_pkg::apb_req_type req = '0;
   timer_pwm_pkg::apb_rsp_type rsp;
   logic [1:0] chPinOut, chPinOe, chIrq, pinLevel;
   logic ovfIrq, err;
   logic [15:0] m;
   logic [31:0] rd;
   int highCount [2];
   int edgeCount [2];
   int fails = 0;
   int testsRun = 0;
   int cycles = 0;

   timer_compare_pwm_channels #(.NUM_CH(2)) i_timer_compare_pwm_channels (.core_clk(core_clk), .rst(rst),
      .apbReq(req), .apbRsp(rsp), .fixedClkTick(fixedClkTick), .extClkPin(extClkPin),
      .chPinOut(chPinOut), .chPinOe(chPinOe), .chIrq(chIrq), .ovfIrq(ovfIrq));
   pin_load_model #(.NUM_CH(2)) i_pin_load_model (.core_clk(core_clk), .clear(clear), .chPinOut(chPinOut),
      .chPinOe(chPinOe), .pinLevel(pinLevel), .highCount(highCount), .edgeCount(edgeCount));

   // ==================================================================
   // clock, clock sources and hang guard
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      fixedClkTick <= cycles % 4 == 3;
      extClkPin <= cycles[2];
      if (cycles > 40000) begin
         fails++;
         completeRun();
      end
   end

   // ==================================================================
   // bus tasks and checks
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
      @(posedge core_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check("register", {24'h0, e}, rd);
   endtask : rdChk

   // wait until every request line whose bit of s is clear stands high
   task automatic waitFor(input logic [1:0] s);
      do begin
         @(posedge core_clk);
      end while (({chIrq[0], ovfIrq} & ~s) !== ~s);
   endtask : waitFor

   // expected high samples per period for either pwm style
   function automatic int highs(input logic ctr, input logic [15:0] v, input logic pol);
      int h;
      int p;
      p = ctr ? 2 * int'(m) : int'(m) + 1;
      if (ctr) h = (v == 16'h0 || v[15]) ? 0 : (v > m) ? p : 2 * int'(v);
      else h = (v == 16'h0) ? 0 : (v > m) ? p : int'(v);
      return pol ? p - h : h;
   endfunction : highs

   // program both channels with the counter stopped, start it, count highs
   task automatic runPwm(input logic ctr, input logic [1:0] sel, input int k, input logic [15:0] v0,
         input logic [15:0] v1);
      int per;
      logic [15:0] v [2];
      per = (ctr ? 2 * int'(m) : int'(m) + 1) * k;
      v = '{v0, v1};
      apb(1'b1, 12'h000, {2'b00, ctr, 5'h00});
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 12'h020 + 12'(16 * i), i ? 8'h2c : 8'h28);
         apb(1'b1, 12'h024 + 12'(16 * i), v[i][15:8]);
         apb(1'b1, 12'h028 + 12'(16 * i), v[i][7:0]);
      end
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h000, {2'b00, ctr, sel, 3'h0});
      repeat (2 * per) @(posedge core_clk);
      clear <= 1'b1;
      @(posedge core_clk);
      clear <= 1'b0;
      repeat (4 * per + 1) @(posedge core_clk);
      check("high0", 4 * k * highs(ctr, v0, 1'b0), highCount[0]);
      check("high1", 4 * k * highs(ctr, v1, 1'b1), highCount[1]);
   endtask : runPwm

   task automatic completeRun();
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : completeRun

   // ==================================================================
   // main sequence
   initial begin
      logic [7:0] lo;
      logic [1:0] s;
      void'($urandom(32'h39e5a200));
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      clear <= 1'b0;
      check("oe", 32'h0, {30'h0, chPinOe});
      rdChk(12'h000, 8'h00);
      rdChk(12'h020, 8'h00);
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, i ? 12'h02c : 12'h014, 8'h00);
         check("slverr", 32'h1, {31'h0, err});
      end
      m = 16'(8 + $urandom_range(8)); // modulus within 0x0008..0x0010
      apb(1'b1, 12'h00c, 8'h00);
      apb(1'b1, 12'h000, 8'h00);
      apb(1'b1, 12'h010, m[7:0]);
      rdChk(12'h010, 8'h00);
      apb(1'b1, 12'h00c, 8'h00);
      rdChk(12'h010, m[7:0]);
      lo = 8'(1 + $urandom_range(int'(m) - 1));
      apb(1'b1, 12'h020, 8'h54);
      apb(1'b1, 12'h024, 8'h12);
      apb(1'b1, 12'h020, 8'h54);
      apb(1'b1, 12'h028, lo);
      rdChk(12'h028, 8'h00);
      apb(1'b1, 12'h024, 8'h00);
      rdChk(12'h028, lo);
      apb(1'b1, 12'h000, 8'h0b);
      s = 2'b01;
      waitFor(s);
      rdChk(12'h020, 8'hd4);
      apb(1'b1, 12'h020, 8'h54);
      repeat (3) @(posedge core_clk);
      check("chIrq", 32'h0, {31'h0, chIrq[0]});
      clear <= 1'b1;
      @(posedge core_clk);
      clear <= 1'b0;
      repeat (32 * (int'(m) + 1) + 1) @(posedge core_clk);
      check("toggles", 32'h4, edgeCount[0]);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 12'h020, i ? 8'h18 : 8'h1c);
         repeat (16 * (int'(m) + 1)) @(posedge core_clk);
         check("pin", {31'h0, ~1'(i)}, {31'h0, pinLevel[0]});
      end
      for (int r = 0; r < 3; r++) begin
         runPwm(1'b0, timer_pwm_pkg::CLK_BUS, 1, 16'(1 + $urandom_range(int'(m) - 1)), 16'($urandom_range(int'(m))));
         runPwm(1'b1, timer_pwm_pkg::CLK_BUS, 1, 16'(1 + $urandom_range(int'(m) - 1)), 16'(1 + $urandom_range(int'(m) - 1)));
      end
      runPwm(1'b0, timer_pwm_pkg::CLK_BUS, 1, 16'h0000, m + 16'h1);
      runPwm(1'b0, timer_pwm_pkg::CLK_FIXED, 4, m + 16'h1, 16'h0000);
      runPwm(1'b0, timer_pwm_pkg::CLK_EXTERNAL, 8, m - 16'h1, 16'h0002);
      runPwm(1'b1, timer_pwm_pkg::CLK_BUS, 1, 16'h0000, 16'h0002);
      runPwm(1'b1, timer_pwm_pkg::CLK_BUS, 1, 16'h8003, 16'h0001);
      runPwm(1'b1, timer_pwm_pkg::CLK_BUS, 1, m + 16'h1, m);
      rdChk(12'h000, 8'ha8);
      apb(1'b1, 12'h000, 8'h68);
      s = 2'b10;
      waitFor(s);
      rdChk(12'h000, 8'he8);
      apb(1'b1, 12'h000, 8'h68);
      repeat (3) @(posedge core_clk);
      check("ovfIrq", 32'h0, {31'h0, ovfIrq});
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rdChk(12'h000, 8'h00);
      check("oe", 32'h0, {30'h0, chPinOe});
      completeRun();
   end
endmodule : timer_compare_pwm_channels_test

`default_nettype wire

// file: timer_pwm_pkg.sv
// constants, register map and carrier types of the timer compare and pwm channels
package timer_pwm_pkg;

   // ==================================================================
   // register map (byte addresses, one aligned word each)
   localparam logic [11:0] TIMER_CONTROL_OFS = 12'h000;
   localparam logic [11:0] COUNTER_HIGH_OFS = 12'h004;
   localparam logic [11:0] COUNTER_LOW_OFS = 12'h008;
   localparam logic [11:0] MODULUS_HIGH_OFS = 12'h00c;
   localparam logic [11:0] MODULUS_LOW_OFS = 12'h010;
   localparam logic [11:0] CHANNEL_BASE_OFS = 12'h020;
   localparam logic [11:0] CHANNEL_STRIDE = 12'h010;
   localparam logic [11:0] CH_CONTROL_OFS = 12'h000;
   localparam logic [11:0] CH_VALUE_HIGH_OFS = 12'h004;
   localparam logic [11:0] CH_VALUE_LOW_OFS = 12'h008;
   localparam int MAX_CHANNELS = 8;

   // ==================================================================
   // timer_control_register fields
   localparam int TC_OVERFLOW_FLAG = 7;
   localparam int TC_OVERFLOW_IRQ_ENABLE = 6;
   localparam int TC_CENTER_ALIGN = 5;
   localparam int TC_CLOCK_SEL_HI = 4;
   localparam int TC_CLOCK_SEL_LO = 3;
   localparam int TC_PRESCALE_HI = 2;
   localparam int TC_PRESCALE_LO = 0;

   // ==================================================================
   // channel_control_register fields
   localparam int CC_EVENT_FLAG = 7;
   localparam int CC_IRQ_ENABLE = 6;
   localparam int CC_MODE_B = 5;
   localparam int CC_MODE_A = 4;
   localparam int CC_EDGE_LEVEL_B = 3;
   localparam int CC_EDGE_LEVEL_A = 2;

   // ==================================================================
   // clock_source_select encodings
   localparam logic [1:0] CLK_OFF = 2'h0;
   localparam logic [1:0] CLK_BUS = 2'h1;
   localparam logic [1:0] CLK_FIXED = 2'h2;
   localparam logic [1:0] CLK_EXTERNAL = 2'h3;

   // ==================================================================
   // counter constants
   localparam logic [15:0] COUNT_FULL = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // ==================================================================
   // carrier types
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic flag;
      logic armed;
      logic ie;
      logic modeB;
      logic modeA;
      logic elsB;
      logic elsA;
      logic [15:0] val;
      logic [7:0] bufHi;
      logic [7:0] bufLo;
      logic gotHi;
      logic gotLo;
      logic out;
      logic oe;
      logic irq;
   } chan_type;

endpackage : timer_pwm_pkg
